// file: hw/solm_port_regs.svh
`ifndef SOLM_PORT_REGS_SVH
`define SOLM_PORT_REGS_SVH
// Number of monitored solenoid channels
`define CHAN_COUNT 5
// Default serial frame length in bits
`define FRAME_BITS 8
// Width of the serial bit counter
`define CNT_BITS 4
// Constants at the widths they meet
`define ZERO_CNT 4'h0
`define ONE_CNT 4'h1
`define ZERO_CHAN 5'h00
`define ZERO_CFG 3'h0
`endif

// file: hw/solm_port_pkg.sv
package solm_port_pkg;
  // Port sequencing states
  typedef enum logic [1:0] {
    PORT_IDLE,
    PORT_SHIFT
  } port_state_t;
endpackage : solm_port_pkg

// file: hw/pin_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for pin inputs
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  // Next values: first stage feeds only the second
  always_comb begin
    nxt_meta = pin_in;
    nxt_sync = meta_ff;
  end

  // Registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_ff <= INIT;
      sync_ff <= INIT;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign pin_out = sync_ff;
endmodule : pin_sync

// file: hw/solm_spi_port.sv
`timescale 1ns/1ps
`include "solm_port_regs.svh"
// Operation
// - The serial output is driven only while chip select is low and floats otherwise.
// - While selected the output bit changes on each falling serial clock edge.
// - While selected the input bit is captured on each rising serial clock edge.
// - An undriven chip select reads high through a pull-up and counts as deselected.
// - Serial clock activity while chip select is high shifts nothing and changes no state.
// - A high reset input clears every fault bit and floats the serial output.
// - Each of the five channels keeps its own fault bit and reset clears all of them.
module solm_spi_port import solm_port_pkg::*; #(
  parameter int FRAME_LEN = `FRAME_BITS
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic chip_sel_n,
  input wire logic serial_clk,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  input wire logic reset_pin,
  input wire logic [`CHAN_COUNT-1:0] fault_event,
  output logic [`CHAN_COUNT-1:0] fault_bits,
  output logic [`FRAME_BITS-1:0] rx_word,
  output logic rx_valid
);
  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [3:0] pins_sync;
  logic cs_n_s;
  logic sclk_s;
  logic si_s;
  logic rst_s;

  // Chip select resets high so an idle, undriven pin means deselected
  pin_sync #(.WIDTH(4), .INIT(4'h1)) pin_sync_inst (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .pin_in({reset_pin, serial_in, serial_clk, chip_sel_n}),
    .pin_out(pins_sync)
  );
  assign cs_n_s = pins_sync[0];
  assign sclk_s = pins_sync[1];
  assign si_s = pins_sync[2];
  assign rst_s = pins_sync[3];

  // ************************************************************
  // Edge detect and state
  // ************************************************************
  logic sclk_d_ff;
  logic nxt_sclk_d;
  logic sclk_rise;
  logic sclk_fall;
  port_state_t state_ff;
  port_state_t nxt_state;
  logic [`FRAME_BITS-1:0] shreg_ff;
  logic [`FRAME_BITS-1:0] nxt_shreg;
  logic [`CNT_BITS-1:0] cnt_ff;
  logic [`CNT_BITS-1:0] nxt_cnt;
  logic out_ff;
  logic nxt_out;
  logic oe_ff;
  logic nxt_oe;
  logic [`CHAN_COUNT-1:0] fault_ff;
  logic [`CHAN_COUNT-1:0] nxt_fault;
  logic [`FRAME_BITS-1:0] rxw_ff;
  logic [`FRAME_BITS-1:0] nxt_rxw;
  logic rxv_ff;
  logic nxt_rxv;
  logic selected;

  // Edges only count while selected; a deselected clock is ignored
  assign selected = !cs_n_s && !rst_s;
  assign sclk_rise = selected && sclk_s && !sclk_d_ff;
  assign sclk_fall = selected && !sclk_s && sclk_d_ff;

  // Load image: fault bits in the high positions, rest zero
  function automatic logic [`FRAME_BITS-1:0] load_word(input logic [`CHAN_COUNT-1:0] f);
    load_word = {f, `ZERO_CFG};
  endfunction : load_word

  // ************************************************************
  // Shift engine next-state
  // ************************************************************
  always_comb begin
    nxt_sclk_d = sclk_s;
    nxt_state = state_ff;
    nxt_shreg = shreg_ff;
    nxt_cnt = cnt_ff;
    nxt_out = out_ff;
    nxt_oe = selected;
    nxt_rxw = rxw_ff;
    nxt_rxv = 1'b0;
    // Fault events are sticky; a set in the clear cycle is lost, the clear wins
    nxt_fault = fault_ff | fault_event;
    case (state_ff)
      PORT_IDLE: begin
        if (selected) begin
          // Snapshot faults at select and present the first bit
          nxt_shreg = load_word(fault_ff);
          nxt_out = fault_ff[`CHAN_COUNT-1];
          nxt_cnt = `ZERO_CNT;
          nxt_state = PORT_SHIFT;
        end
      end
      PORT_SHIFT: begin
        if (!selected) begin
          nxt_state = PORT_IDLE;
        end else if (sclk_rise) begin
          nxt_shreg = {shreg_ff[`FRAME_BITS-2:0], si_s};
          if (cnt_ff == `CNT_BITS'(FRAME_LEN - 1)) begin
            nxt_cnt = `ZERO_CNT;
            nxt_rxw = {shreg_ff[`FRAME_BITS-2:0], si_s};
            nxt_rxv = 1'b1;
          end else begin
            nxt_cnt = cnt_ff + `ONE_CNT;
          end
        end else if (sclk_fall) begin
          nxt_out = shreg_ff[`FRAME_BITS-1];
        end
      end
      default: nxt_state = PORT_IDLE;
    endcase
    // Reset pin dominates: clear faults, float output
    if (rst_s) begin
      nxt_fault = `ZERO_CHAN;
      nxt_oe = 1'b0;
      nxt_state = PORT_IDLE;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sclk_d_ff <= 1'b0;
      state_ff <= PORT_IDLE;
      shreg_ff <= '0;
      cnt_ff <= `ZERO_CNT;
      out_ff <= 1'b0;
      oe_ff <= 1'b0;
      fault_ff <= `ZERO_CHAN;
      rxw_ff <= '0;
      rxv_ff <= 1'b0;
    end else begin
      sclk_d_ff <= nxt_sclk_d;
      state_ff <= nxt_state;
      shreg_ff <= nxt_shreg;
      cnt_ff <= nxt_cnt;
      out_ff <= nxt_out;
      oe_ff <= nxt_oe;
      fault_ff <= nxt_fault;
      rxw_ff <= nxt_rxw;
      rxv_ff <= nxt_rxv;
    end
  end

  assign serial_out = out_ff;
  assign serial_out_oe = oe_ff;
  assign fault_bits = fault_ff;
  assign rx_word = rxw_ff;
  assign rx_valid = rxv_ff;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  oe_follows_cs_a: assert property (cs_n_s |=> !serial_out_oe)
    else $error("output driven while deselected");
  oe_on_select_a: assert property (selected |=> serial_out_oe)
    else $error("output not driven while selected");
  out_on_fall_a: assert property ($changed(serial_out) && $past(state_ff) == PORT_SHIFT
      |-> $past(sclk_fall))
    else $error("output changed off a falling edge");
  shift_on_rise_a: assert property (state_ff == PORT_SHIFT && sclk_rise && selected
      |=> shreg_ff[0] == $past(si_s))
    else $error("input bit not captured");
  idle_no_shift_a: assert property (state_ff == PORT_SHIFT && !sclk_rise
      |=> $stable(cnt_ff) || state_ff == PORT_IDLE)
    else $error("shift without rising edge");
  reset_clears_a: assert property (rst_s |=> fault_bits == `ZERO_CHAN && !serial_out_oe)
    else $error("reset pin did not clear");
  fault_sticky_a: assert property (!rst_s && fault_event[0] |=> fault_bits[0])
    else $error("fault event lost");
  frame_done_a: assert property (rx_valid |-> $past(cnt_ff) == `CNT_BITS'(FRAME_LEN - 1))
    else $error("frame ended on wrong count");

  // Deselected clocks must leave the shifter and counter untouched
  desel_frozen_a: assert property (cs_n_s |=> $stable(shreg_ff) && $stable(cnt_ff))
    else $error("shift state moved while deselected");

  // Idle output holds; a glitch here would reach the pin on the next select
  idle_out_quiet_a: assert property (state_ff == PORT_IDLE && !selected |=> $stable(serial_out))
    else $error("output moved while idle");

  // The first bit out is the top fault bit of the snapshot
  first_bit_a: assert property (state_ff == PORT_IDLE && selected
      |=> serial_out == $past(fault_ff[`CHAN_COUNT-1]))
    else $error("first bit not the top fault bit");

  // Received word only moves together with its valid pulse
  word_holds_a: assert property (!rx_valid |-> $stable(rx_word))
    else $error("received word changed without valid");

  // Scenario covers: full frame, reset with faults, cut frame, deselected clock, output step
  frame_cov_c: cover property (rx_valid);
  reset_cov_c: cover property (rst_s && fault_bits != `ZERO_CHAN);
  abort_cov_c: cover property (state_ff == PORT_SHIFT && cnt_ff != `ZERO_CNT && cs_n_s);
  desel_clk_c: cover property (cs_n_s && sclk_s && !sclk_d_ff);
  fall_cov_c: cover property (sclk_fall);
endmodule : solm_spi_port

// file: verification/spi_host_model.sv
`timescale 1ns/1ps
// ****
// Host side of the serial link
// ****
module spi_host_model (
  output wire logic chip_sel_n,
  output logic serial_clk,
  output logic serial_in,
  input wire logic serial_out
);
  logic sel_ff;
  // Select is floated, never driven high, so the pull-up deselects
  assign chip_sel_n = sel_ff ? 1'b0 : 1'bz;
  initial begin
    sel_ff = 1'b0;
    serial_clk = 1'b0;
    serial_in = 1'b1;
  end
  // One frame MSB first; data moves on falling edges, equal phases
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    sel_ff = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      serial_in = tx[i];
      #400 serial_clk = 1'b1;
      rx[i] = serial_out;
      #400 serial_clk = 1'b0;
    end
    #400 sel_ff = 1'b0;
    serial_in = ~serial_in; // Released line must not keep the last bit
  endtask : xfer
  // Clock bursts with select released, which must be ignored; data moves on falls only
  task automatic idle_clk(input int n);
    repeat (n) begin
      #400 serial_clk = 1'b1;
      #400 serial_clk = 1'b0;
      serial_in = ~serial_in;
    end
  endtask : idle_clk
  // Frame cut short after n clocks, so the port must drop the partial word
  task automatic cut_xfer(input int n);
    sel_ff = 1'b1;
    repeat (n) begin
      #400 serial_clk = 1'b1;
      #400 serial_clk = 1'b0;
      serial_in = ~serial_in;
    end
    #400 sel_ff = 1'b0;
  endtask : cut_xfer
  // Plain select hold with no clocks
  task automatic set_sel(input logic s);
    sel_ff = s;
  endtask : set_sel
endmodule : spi_host_model

// file: verification/solm_spi_port_tb.sv
`timescale 1ns/1ps
`include "solm_port_regs.svh"
module solm_spi_port_tb;
  logic clk_sys, resetn, reset_pin, rx_valid, serial_clk, serial_in, serial_out, serial_out_oe;
  tri1 chip_sel_n;
  logic [`CHAN_COUNT-1:0] fault_event, fault_bits, exp_f;
  logic [`FRAME_BITS-1:0] rx_word;
  int errors, samples_checked, frames;
  solm_spi_port solm_spi_port_inst (.clk_sys(clk_sys), .resetn(resetn), .chip_sel_n(chip_sel_n),
    .serial_clk(serial_clk), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .reset_pin(reset_pin), .fault_event(fault_event),
    .fault_bits(fault_bits), .rx_word(rx_word), .rx_valid(rx_valid));
  // Undriven output shows the inverse of the last bit, so a late enable corrupts the frame
  wire so_line;
  assign so_line = serial_out_oe ? serial_out : ~serial_out;
  spi_host_model spi_host_model_inst (.chip_sel_n(chip_sel_n), .serial_clk(serial_clk),
    .serial_in(serial_in), .serial_out(so_line));
  // ****
  // Checking helpers
  // ****
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic end_sim();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim
  // Frame pulses are counted so stray or missing frames show up
  always @(posedge clk_sys) begin
    if (rx_valid === 1'b1) frames <= frames + 1;
  end
  // Raise faults, then run one frame and judge both directions
  task automatic t_frame(input logic [7:0] tx, input logic [4:0] set);
    logic [7:0] rx;
    int n;
    n = frames;
    @(posedge clk_sys);
    #10 fault_event = set;
    @(posedge clk_sys);
    #10 fault_event = '0;
    exp_f = exp_f | set;
    fork
      spi_host_model_inst.xfer(tx, rx);
      #1000 check("oe_sel", serial_out_oe, 8'h01);
    join
    repeat (4) @(posedge clk_sys);
    #10;
    check("faults", fault_bits, exp_f);
    check("tx_word", rx, {exp_f, 3'b000});
    check("rx_word", rx_word, tx);
    check("frames", 8'(frames - n), 8'h01);
    check("oe_idle", serial_out_oe, 8'h00);
  endtask : t_frame
  // Ten clocks while deselected, then a cut frame; a kept count would skew the next frame
  task automatic t_ignore();
    logic [7:0] w;
    int n;
    n = frames;
    w = rx_word;
    spi_host_model_inst.idle_clk(10);
    spi_host_model_inst.cut_xfer(3);
    repeat (4) @(posedge clk_sys);
    #10;
    check("ign_frames", 8'(frames - n), 8'h00);
    check("ign_word", rx_word, w);
    check("ign_oe", serial_out_oe, 8'h00);
  endtask : t_ignore
  // Reset pin while selected: faults wiped, output floated, and a fault in reset is not kept
  task automatic t_resetpin();
    spi_host_model_inst.set_sel(1'b1);
    repeat (5) @(posedge clk_sys);
    #10;
    check("rp_sel_oe", serial_out_oe, 8'h01);
    reset_pin = 1'b1;
    repeat (5) @(posedge clk_sys);
    #10 fault_event = 5'h1F;
    @(posedge clk_sys);
    #10 fault_event = '0;
    repeat (2) @(posedge clk_sys);
    #10;
    check("rp_faults", fault_bits, 8'h00);
    check("rp_oe", serial_out_oe, 8'h00);
    spi_host_model_inst.set_sel(1'b0);
    reset_pin = 1'b0;
    exp_f = '0;
    repeat (4) @(posedge clk_sys);
    #10;
  endtask : t_resetpin
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Watchdog well beyond the few frames the run needs
  initial begin
    #200000;
    errors++;
    end_sim();
  end
  initial begin
    resetn = 1'b0;
    reset_pin = 1'b0;
    fault_event = '0;
    exp_f = '0;
    errors = 0;
    samples_checked = 0;
    frames = 0;
    repeat (5) @(posedge clk_sys);
    #10 resetn = 1'b1;
    repeat (4) @(posedge clk_sys);
    check("rst_faults", fault_bits, 8'h00);
    check("rst_oe", serial_out_oe, 8'h00);
    t_frame(8'hA5, 5'h16);
    t_frame(8'h5A, 5'h01);
    t_ignore();
    t_frame(8'hFF, 5'h08);
    t_resetpin();
    t_frame(8'h00, 5'h00);
    end_sim();
  end
endmodule : solm_spi_port_tb
